// ===== include/ctm_params.svh
// Purpose: Constants for the instruction timing decoder
// Assumes: One clock, states counted in core clock cycles
// Notes:   Cost words pack binary bytes, states, source bytes, states
`ifndef CTM_PARAMS_SVH
`define CTM_PARAMS_SVH

`define CTM_PC_W        24
`define CTM_BW          3
`define CTM_SW          6
`define CTM_NW          2
`define CTM_CFG_SETTLE  2'h2
`define CTM_ONE_STATE   6'h01

// Penalty for a direct operand that hits a port or peripheral register
`define CTM_PEN_NONE    6'h00
`define CTM_PEN_PORT    6'h01
`define CTM_PEN_PERIPH  6'h02

// Extra states for a target that is odd or external
`define CTM_PEN_ODD     6'h01
`define CTM_PEN_EXT_PG  6'h02
`define CTM_PEN_EXT_JMP 6'h03
`define CTM_PEN_EXT_CAL 6'h02

// External memory extension addends
`define CTM_EXT_B_ADD   6'h02
`define CTM_EXT_W_ADD   6'h01
`define CTM_EXT_D_ADD   6'h02

// Program counter steps and fixed fields
`define CTM_PC_STEP_REL 24'h000002
`define CTM_PC_STEP_PG  24'h000002
`define CTM_PC_HI_IDX   8'hff
`define CTM_PG_BITS     11

// Costs: {bin bytes, bin states, src bytes, src states}
`define CTM_C_LOG_DIR   {3'h2, 6'h01, 3'h2, 6'h01}
`define CTM_C_LOG_IND   {3'h1, 6'h02, 3'h2, 6'h03}
`define CTM_C_LOG_DIMM  {3'h3, 6'h03, 3'h3, 6'h03}
`define CTM_C_LOG_WIMM  {3'h5, 6'h04, 3'h4, 6'h03}
`define CTM_C_ACC_UN    {3'h1, 6'h01, 3'h1, 6'h01}
`define CTM_C_REG_REG   {3'h3, 6'h02, 3'h2, 6'h01}
`define CTM_C_MOV_DD    {3'h3, 6'h03, 3'h3, 6'h03}
`define CTM_C_DATA_POINTER_REG_LD   {3'h3, 6'h02, 3'h3, 6'h02}
`define CTM_C_MOV_XB    {3'h5, 6'h03, 3'h4, 6'h02}
`define CTM_C_MOV_XW    {3'h5, 6'h04, 3'h4, 6'h03}
`define CTM_C_MOV_XD    {3'h5, 6'h06, 3'h4, 6'h05}
`define CTM_C_MOV_D8DW  {3'h4, 6'h06, 3'h3, 6'h05}
`define CTM_C_MOV_DISP  {3'h5, 6'h06, 3'h4, 6'h05}
`define CTM_C_JMP_IDX   {3'h1, 6'h05, 3'h1, 6'h05}
`define CTM_C_JMP_WIDE  {3'h3, 6'h05, 3'h3, 6'h05}
`define CTM_C_JMP_REL   {3'h2, 6'h04, 3'h2, 6'h04}
`define CTM_C_IDLE      {3'h1, 6'h01, 3'h1, 6'h01}
`define CTM_C_JMP_PAGE  {3'h2, 6'h03, 3'h2, 6'h03}
`define CTM_C_CALL_WI   {3'h3, 6'h0a, 3'h2, 6'h09}
`define CTM_C_CALL_FI   {3'h3, 6'h0e, 3'h2, 6'h0d}

`endif

// ===== include/ctm_pkg.sv
// Purpose: Types for the instruction timing decoder
// Assumes: ctm_params.svh supplies widths
// Notes:   Requests and answers travel as packed structs
`include "ctm_params.svh"

package ctm_pkg;

  typedef enum logic [4:0] {
    OP_LOG_DIR, OP_LOG_IND, OP_LOG_DIMM, OP_LOG_WIMM, OP_ACC_UNARY,
    OP_REG_REG, OP_MOV_DD, OP_DATA_POINTER_REG_LD, OP_MOV_XB, OP_MOV_XW, OP_MOV_XD,
    OP_MOV_D8DW, OP_MOV_DISP, OP_JMP_IDX, OP_JMP_WIDE, OP_JMP_REL,
    OP_IDLE, OP_JMP_PAGE, OP_CALL_WI, OP_CALL_FI
  } ctm_op_t;

  typedef enum logic [1:0] {DK_RAM, DK_PORT, DK_PERIPH} ctm_dkind_t;

  typedef enum logic [1:0] {SZ_NONE, SZ_BYTE, SZ_WORD, SZ_DWORD} ctm_size_t;

  typedef enum logic [1:0] {S_CFG, S_IDLE, S_EXEC} ctm_fsm_t;

  typedef struct packed {
    logic [`CTM_BW-1:0] bin_bytes;
    logic [`CTM_SW-1:0] bin_states;
    logic [`CTM_BW-1:0] src_bytes;
    logic [`CTM_SW-1:0] src_states;
  } ctm_cost_t;

  typedef struct packed {
    logic                 valid;
    ctm_op_t              op;
    ctm_dkind_t           dir_a;
    ctm_dkind_t           dir_b;
    logic                 ext_mem;
    logic [`CTM_NW-1:0]   wait_n;
    logic                 exec_internal;
    logic                 tgt_ext;
    logic [`CTM_PC_W-1:0] pc;
    logic [`CTM_PC_W-1:0] operand;
    logic [7:0]           rel;
    logic [7:0]           work_reg;
    logic [15:0]          data_pointer_reg;
  } ctm_req_t;

  typedef struct packed {
    logic                 valid;
    logic [`CTM_BW-1:0]   bytes;
    logic [`CTM_SW-1:0]   states;
    logic [`CTM_PC_W-1:0] next_pc;
  } ctm_rsp_t;

  typedef struct packed {
    logic                 sync1;
    logic                 sync2;
    logic [1:0]           cfg_cnt;
    logic                 src_mode;
    ctm_fsm_t             fsm;
    logic                 ready;
    logic [`CTM_SW-1:0]   cnt;
    ctm_rsp_t             rsp;
  } ctm_state_t;

endpackage : ctm_pkg

// ===== core/ctm_ext_wait.sv
// Purpose: Extra states for moves that reach external memory
// Assumes: Wait state count is stable while the request is offered
// Notes:   Pure combinational, no state
`include "ctm_params.svh"
`timescale 1ns/1ns

module ctm_ext_wait
  import ctm_pkg::*;
(
  // Access description
  input  wire ctm_size_t         size,
  input  wire logic              ext_en,
  input  wire logic [`CTM_NW-1:0] wait_n,
  // Result
  output logic [`CTM_SW-1:0]     extra
);

  logic [`CTM_SW-1:0] n6;

  assign n6 = {{(`CTM_SW-`CTM_NW){1'b0}}, wait_n};

  always_comb begin
    extra = `CTM_PEN_NONE;
    if (ext_en) begin
      case (size)
        SZ_BYTE:  extra = n6 + `CTM_EXT_B_ADD;
        SZ_WORD:  extra = (n6 + `CTM_EXT_W_ADD) << 1;
        SZ_DWORD: extra = (n6 + `CTM_EXT_D_ADD) << 2;
        default:  extra = `CTM_PEN_NONE;
      endcase
    end
  end

endmodule : ctm_ext_wait

// ===== core/ctm_timing_core.sv
// Purpose: Instruction length, state count and next program counter
// Assumes: Requests come from logic on clk; mode strap is a pin
// Notes:   One instruction at a time, answer after its state count
//
// Notes on behaviour
// - Logic with direct operand: 2 bytes, 1 state
// - Indirect byte to work register: 1/2, 2/3
// - Logic immediate to direct: 3 bytes, 3 states
// - Word register with 16-bit immediate: 5/4, 4/3
// - Work register unary ops: 1 byte, 1 state
// - Byte register pair: 3/2 binary, 2/1 source
// - Port operand adds 1, peripheral adds 2
// - Direct to direct move: penalty per operand
// - Direct to direct move: 3 bytes, 3 states
// - Data pointer load: 3 bytes, 2 states
// - External byte move adds N plus 2
// - External word move adds 2 times N+1
// - External dword move adds 4 times N+2
// - Direct to dword register: 4/6, 3/5
// - Displaced pointer byte load: 5/6, 4/5
// - Indexed jump: high byte ones, 1/5
// - Wide jump replaces low 16 bits, 3/5
// - Relative jump: pc+2+offset, 2 bytes, 4
// - Idle op: pc+1, 1 byte, 1 state
// - Odd internal target adds one state
// - External target: page jump and calls 2, other jumps 3
// - Indirect calls: wide 10/9, far 14/13
`include "ctm_params.svh"
`timescale 1ns/1ns

module ctm_timing_core
  import ctm_pkg::*;
(
  // Clock, reset, enable
  input  wire logic     clk,
  input  wire logic     reset,
  input  wire logic     ce,
  // Mode strap, high selects source mode
  input  wire logic     mode_pin,
  // Instruction request
  input  wire ctm_req_t req,
  output ctm_rsp_t      rsp,
  output logic          req_ready,
  // Selected opcode mode
  output logic          src_mode
);

  localparam ctm_state_t ST_RESET = '0;

  ctm_state_t st_reg;
  ctm_state_t st_next;

  ctm_cost_t             cost;
  ctm_size_t             acc_size;
  logic [`CTM_BW-1:0]    base_bytes;
  logic [`CTM_SW-1:0]    base_states;
  logic [`CTM_SW-1:0]    dir_states;
  logic [`CTM_SW-1:0]    ext_states;
  logic [`CTM_SW-1:0]    jump_states;
  logic [`CTM_SW-1:0]    total_states;
  logic [`CTM_PC_W-1:0]  pc_seq;
  logic [`CTM_PC_W-1:0]  pc_rel;
  logic [`CTM_PC_W-1:0]  target;
  logic                  ext_en;

  // Cost table lookup
  function automatic ctm_cost_t cost_of(input ctm_op_t op);
    case (op)
      OP_LOG_DIR:   cost_of = `CTM_C_LOG_DIR;
      OP_LOG_IND:   cost_of = `CTM_C_LOG_IND;
      OP_LOG_DIMM:  cost_of = `CTM_C_LOG_DIMM;
      OP_LOG_WIMM:  cost_of = `CTM_C_LOG_WIMM;
      OP_ACC_UNARY: cost_of = `CTM_C_ACC_UN;
      OP_REG_REG:   cost_of = `CTM_C_REG_REG;
      OP_MOV_DD:    cost_of = `CTM_C_MOV_DD;
      OP_DATA_POINTER_REG_LD:   cost_of = `CTM_C_DATA_POINTER_REG_LD;
      OP_MOV_XB:    cost_of = `CTM_C_MOV_XB;
      OP_MOV_XW:    cost_of = `CTM_C_MOV_XW;
      OP_MOV_XD:    cost_of = `CTM_C_MOV_XD;
      OP_MOV_D8DW:  cost_of = `CTM_C_MOV_D8DW;
      OP_MOV_DISP:  cost_of = `CTM_C_MOV_DISP;
      OP_JMP_IDX:   cost_of = `CTM_C_JMP_IDX;
      OP_JMP_WIDE:  cost_of = `CTM_C_JMP_WIDE;
      OP_JMP_REL:   cost_of = `CTM_C_JMP_REL;
      OP_IDLE:      cost_of = `CTM_C_IDLE;
      OP_JMP_PAGE:  cost_of = `CTM_C_JMP_PAGE;
      OP_CALL_WI:   cost_of = `CTM_C_CALL_WI;
      OP_CALL_FI:   cost_of = `CTM_C_CALL_FI;
      default:      cost_of = `CTM_C_IDLE;
    endcase
  endfunction : cost_of

  // Penalty of one direct operand
  function automatic logic [`CTM_SW-1:0] dir_pen(input ctm_dkind_t k);
    case (k)
      DK_PORT:   dir_pen = `CTM_PEN_PORT;
      DK_PERIPH: dir_pen = `CTM_PEN_PERIPH;
      default:   dir_pen = `CTM_PEN_NONE;
    endcase
  endfunction : dir_pen

  // Ops that change flow and pay target penalties
  function automatic logic is_branch(input ctm_op_t op);
    case (op)
      OP_JMP_IDX, OP_JMP_WIDE, OP_JMP_REL, OP_JMP_PAGE,
      OP_CALL_WI, OP_CALL_FI: is_branch = 1'b1;
      default:                is_branch = 1'b0;
    endcase
  endfunction : is_branch

  // Ops whose first operand is a short direct address
  function automatic logic has_dir(input ctm_op_t op);
    case (op)
      OP_LOG_DIR, OP_LOG_DIMM, OP_MOV_DD: has_dir = 1'b1;
      default:                            has_dir = 1'b0;
    endcase
  endfunction : has_dir

  // Width of a move that may reach external memory
  function automatic ctm_size_t size_of(input ctm_op_t op);
    case (op)
      OP_MOV_XB, OP_MOV_DISP: size_of = SZ_BYTE;
      OP_MOV_XW:              size_of = SZ_WORD;
      OP_MOV_XD:              size_of = SZ_DWORD;
      default:                size_of = SZ_NONE;
    endcase
  endfunction : size_of

  // Mode selected sizes
  always_comb begin
    cost = cost_of(req.op);
    if (st_reg.src_mode) begin
      base_bytes  = cost.src_bytes;
      base_states = cost.src_states;
    end else begin
      base_bytes  = cost.bin_bytes;
      base_states = cost.bin_states;
    end
  end

  // Direct operand penalties
  always_comb begin
    dir_states = `CTM_PEN_NONE;
    if (has_dir(req.op)) begin
      dir_states = dir_pen(req.dir_a);
    end
    if (req.op == OP_MOV_DD) begin
      dir_states = dir_states + dir_pen(req.dir_b);
    end
  end

  // External memory extension
  assign acc_size = size_of(req.op);
  assign ext_en   = req.ext_mem && (acc_size != SZ_NONE);

  ctm_ext_wait u_ext_wait (
    .size   (acc_size),
    .ext_en (ext_en),
    .wait_n (req.wait_n),
    .extra  (ext_states)
  );

  // Program counter after the instruction
  always_comb begin
    pc_seq = req.pc + {{(`CTM_PC_W-`CTM_BW){1'b0}}, base_bytes};
    pc_rel = req.pc + `CTM_PC_STEP_REL
             + {{(`CTM_PC_W-8){req.rel[7]}}, req.rel};
    case (req.op)
      OP_IDLE:     target = pc_seq;
      OP_JMP_REL:  target = pc_rel;
      OP_JMP_IDX:  target = {`CTM_PC_HI_IDX,
                             16'(req.data_pointer_reg + {8'h00, req.work_reg})};
      OP_JMP_WIDE: target = {pc_seq[`CTM_PC_W-1:16],
                             req.operand[15:0]};
      OP_CALL_WI:  target = {pc_seq[`CTM_PC_W-1:16],
                             req.operand[15:0]};
      OP_CALL_FI:  target = req.operand;
      OP_JMP_PAGE: begin
        target = req.pc + `CTM_PC_STEP_PG;
        target[`CTM_PG_BITS-1:0] = req.operand[`CTM_PG_BITS-1:0];
      end
      default:     target = pc_seq;
    endcase
  end

  // Target penalties for jumps and calls
  always_comb begin
    jump_states = `CTM_PEN_NONE;
    if (is_branch(req.op)) begin
      if (req.exec_internal && !req.tgt_ext && target[0]) begin
        jump_states = `CTM_PEN_ODD;
      end
      if (req.tgt_ext) begin
        case (req.op)
          OP_JMP_PAGE: jump_states = `CTM_PEN_EXT_PG;
          OP_CALL_WI,
          OP_CALL_FI:  jump_states = `CTM_PEN_EXT_CAL;
          default:     jump_states = `CTM_PEN_EXT_JMP;
        endcase
      end
    end
  end

  assign total_states = base_states + dir_states + ext_states + jump_states;

  // Sequencer
  always_comb begin
    st_next           = st_reg;
    st_next.sync1     = mode_pin;
    st_next.sync2     = st_reg.sync1;
    st_next.rsp.valid = 1'b0;
    case (st_reg.fsm)
      S_CFG: begin
        if (st_reg.cfg_cnt == `CTM_CFG_SETTLE) begin
          st_next.src_mode = st_reg.sync2;
          st_next.fsm      = S_IDLE;
          st_next.ready    = 1'b1;
        end else begin
          st_next.cfg_cnt = st_reg.cfg_cnt + 2'h1;
        end
      end
      S_IDLE: begin
        if (req.valid) begin
          st_next.fsm          = S_EXEC;
          st_next.ready        = 1'b0;
          st_next.cnt          = total_states;
          st_next.rsp.bytes    = base_bytes;
          st_next.rsp.states   = total_states;
          st_next.rsp.next_pc  = target;
        end
      end
      S_EXEC: begin
        if (st_reg.cnt == `CTM_ONE_STATE) begin
          st_next.fsm       = S_IDLE;
          st_next.ready     = 1'b1;
          st_next.rsp.valid = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt - `CTM_ONE_STATE;
        end
      end
      default: begin
        st_next = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= ST_RESET;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign rsp       = st_reg.rsp;
  assign req_ready = st_reg.ready;
  assign src_mode  = st_reg.src_mode;

endmodule : ctm_timing_core

// ===== sim/ctm_timing_core_assertions.sv
// Purpose: Port-level checks of the instruction timing decoder
// Assumes: Bound to ctm_timing_core, one clock domain
// Notes:   cnt_reg counts enabled edges since the last taking edge
`timescale 1ns/1ns

module ctm_timing_core_assertions
  import ctm_pkg::*;
(
  // Clock, reset, enable
  input wire logic     clk,
  input wire logic     reset,
  input wire logic     ce,
  // Request and answer
  input wire ctm_req_t req,
  input wire ctm_rsp_t rsp,
  input wire logic     req_ready,
  input wire logic     src_mode
);
  logic       take;
  logic [5:0] cnt_reg;

  assign take = ce && req_ready && req.valid;

  always_ff @(posedge clk) begin
    if (reset || take)
      cnt_reg <= 6'h00;
    else if (ce)
      cnt_reg <= cnt_reg + 6'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_answer_time;
    rsp.valid |-> cnt_reg == rsp.states && req_ready;
  endproperty
  a_answer_time: assert property (p_answer_time)
    else $error("answer pulse not at the state count");

  property p_answer_due;
    ce && !req_ready && cnt_reg == rsp.states - 6'h01 |=> rsp.valid;
  endproperty
  a_answer_due: assert property (p_answer_due)
    else $error("answer pulse missing at the state count");

  property p_busy;
    take |=> !req_ready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("ready stayed high after a request was taken");

  property p_idle;
    take && req.op == OP_IDLE |=> rsp.bytes == 3'h1 &&
      rsp.states == 6'h01 && rsp.next_pc == $past(req.pc) + 24'h000001;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle op cost or next pc wrong");

  property p_jmp_idx;
    take && req.op == OP_JMP_IDX |=> rsp.next_pc ==
      {8'hff, 16'($past(req.data_pointer_reg) + $past(req.work_reg))};
  endproperty
  a_jmp_idx: assert property (p_jmp_idx)
    else $error("indexed jump target wrong");

  property p_jmp_rel;
    take && req.op == OP_JMP_REL |=> rsp.next_pc == $past(req.pc) +
      24'h000002 + {{16{$past(req.rel[7])}}, $past(req.rel)};
  endproperty
  a_jmp_rel: assert property (p_jmp_rel)
    else $error("relative jump target wrong");

  property p_jmp_wide;
    take && req.op == OP_JMP_WIDE && !req.tgt_ext && !req.exec_internal
      |=> rsp.states == 6'h05 && rsp.next_pc[15:0] == $past(req.operand[15:0]);
  endproperty
  a_jmp_wide: assert property (p_jmp_wide)
    else $error("wide jump cost or target wrong");

  property p_mode_hold;
    req_ready |=> $stable(src_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("opcode mode changed after it was latched");

  property p_freeze;
    !ce |=> $stable(rsp) && $stable(req_ready);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("outputs moved while the clock enable was low");

  c_idle: cover property (take && req.op == OP_IDLE);
  c_long: cover property (rsp.valid && rsp.states > 6'h0c);
  c_stall: cover property (!ce && !req_ready);
endmodule : ctm_timing_core_assertions

bind ctm_timing_core ctm_timing_core_assertions u_chk (
  .clk(clk), .reset(reset), .ce(ce), .req(req), .rsp(rsp),
  .req_ready(req_ready), .src_mode(src_mode));

// ===== sim/tb_ctm_timing_core.sv
// Purpose: Self-checking bench of the instruction timing decoder
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Expected costs come from the table below, per opcode mode
`timescale 1ns/1ns

module tb_ctm_timing_core
  import ctm_pkg::*;
;
  logic     clk, reset, ce, mode_pin, req_ready, src_mode, md;
  ctm_req_t req, base;
  ctm_rsp_t rsp;
  int       num_errors = 0;
  int       tests_run = 0;
  int       cyc = 0;
  // {bin bytes, bin states, src bytes, src states} per op
  logic [15:0] cost [20] = '{16'h2121, 16'h1223, 16'h3333, 16'h5443,
    16'h1111, 16'h3221, 16'h3333, 16'h3232, 16'h5342, 16'h5443, 16'h5645,
    16'h4635, 16'h5645, 16'h1515, 16'h3535, 16'h2424, 16'h1111, 16'h2323,
    16'h3a29, 16'h3e2d};

  ctm_timing_core dut (.clk(clk), .reset(reset), .ce(ce),
    .mode_pin(mode_pin), .req(req), .rsp(rsp), .req_ready(req_ready),
    .src_mode(src_mode));

  always #4 clk = ~clk;

  task automatic report_and_stop;
    if (num_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic logic [23:0] exp_pc(ctm_req_t r, logic [2:0] b);
    logic [23:0] q;
    q = r.pc + 24'(b);
    case (r.op)
      OP_JMP_REL: q = r.pc + 24'h000002 + {{16{r.rel[7]}}, r.rel};
      OP_JMP_IDX: q = {8'hff, r.data_pointer_reg + 16'(r.work_reg)};
      OP_JMP_WIDE, OP_CALL_WI: q = {q[23:16], r.operand[15:0]};
      OP_JMP_PAGE: begin
        q = r.pc + 24'h000002;
        q[10:0] = r.operand[10:0];
      end
      OP_CALL_FI: q = r.operand;
      default: ;
    endcase
    return q;
  endfunction : exp_pc

  task automatic exec(input ctm_req_t r, input logic [5:0] add);
    logic [15:0] c;
    logic [5:0]  s;
    logic [2:0]  b;
    int          n;
    c = cost[r.op];
    b = md ? c[6:4] : c[14:12];
    s = 6'(md ? c[3:0] : c[11:8]) + add;
    r.valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    req = r;
    @(posedge clk);
    #1;
    req.valid = 1'b0;
    n = 0;
    while (rsp.valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("bytes", rsp.bytes, b);
    check("states", rsp.states, s);
    check("edges", n, s);
    check("next_pc", rsp.next_pc, exp_pc(r, b));
  endtask : exec

  task automatic t_reset(input logic m);
    int n;
    reset = 1'b1;
    mode_pin = m;
    md = m;
    req = '0;
    repeat (8) @(posedge clk);
    #1;
    check("rst_ready", req_ready, 32'h0);
    check("rst_rsp", {rsp.valid, rsp.next_pc}, 32'h0);
    reset = 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("cfg_edges", n, 32'h3);
    check("mode", src_mode, m);
    mode_pin = !m;
    repeat (4) @(posedge clk);
    #1;
    check("mode_hold", src_mode, m);
  endtask : t_reset

  task automatic t_table;
    ctm_req_t r;
    for (int i = 0; i < 20; i++) begin
      r = base;
      r.op = ctm_op_t'(i);
      exec(r, 6'h00);
    end
  endtask : t_table

  task automatic t_direct;
    ctm_req_t r;
    r = base;
    r.op = OP_LOG_DIR;
    r.dir_a = DK_PORT;
    exec(r, 6'h01);
    r.dir_a = DK_PERIPH;
    exec(r, 6'h02);
    r.op = OP_LOG_DIMM;
    exec(r, 6'h02);
    r.op = OP_MOV_DD;
    r.dir_b = DK_PORT;
    exec(r, 6'h03);
    r.dir_a = DK_RAM;
    r.dir_b = DK_PERIPH;
    exec(r, 6'h02);
  endtask : t_direct

  task automatic t_ext;
    ctm_req_t r;
    for (int n = 0; n < 4; n++) begin
      r = base;
      r.ext_mem = 1'b1;
      r.wait_n = 2'(n);
      r.op = OP_MOV_XB;
      exec(r, 6'(n + 2));
      r.op = OP_MOV_XW;
      exec(r, 6'(2 * (n + 1)));
      r.op = OP_MOV_XD;
      exec(r, 6'(4 * (n + 2)));
      r.op = OP_MOV_DISP;
      exec(r, 6'(n + 2));
    end
  endtask : t_ext

  task automatic t_branch;
    ctm_req_t r;
    r = base;
    r.tgt_ext = 1'b1;
    r.op = OP_JMP_PAGE;
    exec(r, 6'h02);
    r.op = OP_JMP_WIDE;
    exec(r, 6'h03);
    r.op = OP_JMP_REL;
    exec(r, 6'h03);
    r.op = OP_CALL_WI;
    exec(r, 6'h02);
    r = base;
    r.op = OP_JMP_WIDE;
    r.operand = 24'h001235;
    r.exec_internal = 1'b1;
    exec(r, 6'h01);
    r.op = OP_CALL_FI;
    exec(r, 6'h01);
    r.op = OP_JMP_WIDE;
    r.exec_internal = 1'b0;
    exec(r, 6'h00);
  endtask : t_branch

  task automatic t_stall;
    ctm_req_t r;
    logic     seen;
    int       n;
    r = base;
    r.op = OP_JMP_WIDE;
    r.valid = 1'b1;
    req = r;
    @(posedge clk);
    #1;
    @(posedge clk);
    #1;
    req.valid = 1'b0;
    ce = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    ce = 1'b1;
    n = 4;
    while (rsp.valid !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("stall_edges", n, 32'h8);
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk);
      #1;
      seen = seen | rsp.valid;
    end
    check("refused", seen, 32'h0);
  endtask : t_stall

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    mode_pin = 1'b0;
    req = '0;
    base = '0;
    base.pc = 24'h012340;
    base.operand = 24'h005678;
    base.rel = 8'hf0;
    base.work_reg = 8'h12;
    base.data_pointer_reg = 16'h3456;
    t_reset(1'b0);
    t_table;
    t_direct;
    t_ext;
    t_branch;
    t_stall;
    t_reset(1'b1);
    t_table;
    t_direct;
    t_ext;
    t_branch;
    report_and_stop;
  end
endmodule : tb_ctm_timing_core
